// >>> shared/ldw_regs.svh
`ifndef LDW_REGS_SVH
`define LDW_REGS_SVH

// ==========================================================
// Timing
`define LDW_CLK_PS 10000
`define LDW_T_CH_PS 19000
`define LDW_HALF_CYC ((`LDW_T_CH_PS + `LDW_CLK_PS - 1) / `LDW_CLK_PS)
`define LDW_CS_GAP_CYC 6
`define LDW_DWELL_CYC 100

// ==========================================================
// Command addresses and fields
`define LDW_ADDR_SCAN_LIMIT 8'h03
`define LDW_ADDR_CONFIG 8'h04
`define LDW_CFG_RUN_BIT 0
`define LDW_CFG_CLEAR_BIT 5
`define LDW_DIGIT_P0 3'h1
`define LDW_DIGIT_P1 3'h2
`define LDW_DIGIT_BOTH 3'h3
`define LDW_SEG_A_BIT 6
`define LDW_SEG_DP_BIT 7

// ==========================================================
// Reset values and geometry
`define LDW_SCAN_LIMIT_RST 3'h4
`define LDW_RUN_RST 1'b0
`define LDW_REDUCED_DIGITS 5
`define LDW_PINS 9

`endif

// >>> shared/ldw_pkg.sv
package ldw_pkg;

    typedef enum logic [2:0] {
        LDW_IDLE,
        LDW_CS_SETUP,
        LDW_CLK_LOW,
        LDW_CLK_HIGH,
        LDW_CS_HOLD,
        LDW_CS_GAP
    } ldw_mst_state_t;

    typedef struct packed {
        ldw_mst_state_t state;
        logic [3:0] cnt;
        logic [4:0] idx;
        logic [31:0] word;
        logic idle_high;
        logic sclk;
        logic cs_n;
        logic mosi;
        logic ready;
    } ldw_mst_st_t;

    typedef struct packed {
        logic [2:0] cs_sync;
        logic [15:0] latch;
        logic valid;
        logic [7:0][7:0] digit;
        logic [2:0] scan_limit;
        logic run;
        logic [2:0] cur;
        logic [9:0] dwell;
        logic [8:0] pin_out;
        logic [8:0] pin_oe;
    } ldw_dev_st_t;

endpackage

// >>> shared/ldw_if.sv
`timescale 1ns/1ps
`default_nettype none

interface ldw_if;
    logic sclk;
    logic cs_n;
    logic mosi;

    modport master (
        output sclk,
        output cs_n,
        output mosi
    );

    modport device (
        input sclk,
        input cs_n,
        input mosi
    );
endinterface

`default_nettype wire

// >>> hw/ldw_master.sv
`timescale 1ns/1ps
`default_nettype none
`include "ldw_regs.svh"

module ldw_master
    import ldw_pkg::*;
(
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_reset_n,
    // Link
    ldw_if.master link,
    // User request
    input wire logic i_start,
    input wire logic [31:0] i_word,
    input wire logic [5:0] i_nbits,
    input wire logic i_idle_high,
    output logic o_ready
);

    // ==========================================================
    // State
    localparam logic [3:0] HALF = 4'(`LDW_HALF_CYC - 1);
    localparam logic [3:0] GAP = 4'(`LDW_CS_GAP_CYC - 1);

    ldw_mst_st_t q, d;

    always_comb begin
        d = q;
        if (q.state != LDW_IDLE) begin
            d.cnt = q.cnt - 4'h1;
        end
        unique case (q.state)
            LDW_IDLE: begin
                d.idle_high = i_idle_high;
                // The idle level may only move while select is high; moving it on the
                // edge that lowers select would hand the device a spurious rising edge.
                if (!(i_start && i_nbits != 6'h0 && i_nbits <= 6'h20)) begin
                    d.sclk = i_idle_high;
                end
                if (i_start && i_nbits != 6'h0 && i_nbits <= 6'h20) begin
                    d.word = i_word;
                    d.idx = 5'(i_nbits - 6'h1);
                    d.cs_n = 1'b0;
                    d.ready = 1'b0;
                    d.cnt = HALF;
                    d.state = LDW_CS_SETUP;
                end
            end
            LDW_CS_SETUP: begin
                if (q.cnt == 4'h0) begin
                    d.sclk = 1'b0;
                    d.mosi = q.word[q.idx];
                    d.cnt = HALF;
                    d.state = LDW_CLK_LOW;
                end
            end
            LDW_CLK_LOW: begin
                if (q.cnt == 4'h0) begin
                    d.sclk = 1'b1;
                    d.cnt = HALF;
                    d.state = LDW_CLK_HIGH;
                end
            end
            LDW_CLK_HIGH: begin
                if (q.cnt == 4'h0) begin
                    d.cnt = HALF;
                    if (q.idx == 5'h0) begin
                        d.sclk = q.idle_high;
                        d.state = LDW_CS_HOLD;
                    end else begin
                        d.idx = q.idx - 5'h1;
                        d.sclk = 1'b0;
                        d.mosi = q.word[q.idx - 5'h1];
                        d.state = LDW_CLK_LOW;
                    end
                end
            end
            LDW_CS_HOLD: begin
                if (q.cnt == 4'h0) begin
                    // The gap lets the device resynchronise select before the next frame.
                    d.cs_n = 1'b1;
                    d.cnt = GAP;
                    d.state = LDW_CS_GAP;
                end
            end
            LDW_CS_GAP: begin
                if (q.cnt == 4'h0) begin
                    d.ready = 1'b1;
                    d.state = LDW_IDLE;
                end
            end
        endcase
    end

    always_ff @(posedge i_clk) begin
        if (!i_reset_n) begin
            q <= '0;
            q.state <= LDW_IDLE;
            q.cs_n <= 1'b1;
            q.ready <= 1'b1;
        end else begin
            q <= d;
        end
    end

    assign link.sclk = q.sclk;
    assign link.cs_n = q.cs_n;
    assign link.mosi = q.mosi;
    assign o_ready = q.ready;

endmodule

`default_nettype wire

// >>> hw/ldw_device.sv
`timescale 1ns/1ps
`default_nettype none
`include "ldw_regs.svh"

module ldw_device
    import ldw_pkg::*;
#(
    parameter bit FULL_SIZE = 1'b1
) (
    // Multiplex clock and reset
    input wire logic i_clk,
    input wire logic i_reset_n,
    // Link, clocked by its own serial clock
    ldw_if.device link,
    // Command strobe
    output logic o_cmd_valid,
    output logic [7:0] o_cmd_addr,
    output logic [7:0] o_cmd_data,
    // Combined digit and segment pins
    output logic [8:0] o_pin_out,
    output logic [8:0] o_pin_oe,
    // Scan state
    output logic o_running
);

    // ==========================================================
    // Link domain: shift register
    // Select is treated as synchronous to the serial clock, since the master
    // meets a setup time to the rising edge. The shift register has no reset
    // because the link has no reset pin; its first word is only defined
    // after sixteen bits have been clocked in.
    logic [15:0] shift_q;

    always_ff @(posedge link.sclk) begin
        if (!link.cs_n) begin
            shift_q <= {shift_q[14:0], link.mosi};
        end
    end

    // ==========================================================
    // Multiplex domain
    // Only rising edges are used, so either idle level of the serial clock
    // is harmless.
    ldw_dev_st_t q, d;
    logic cs_rise;
    logic lit_ok;
    logic [2:0] seg_idx;
    logic [2:0] seg_bit;

    always_comb begin
        d = q;
        cs_rise = 1'b0;
        lit_ok = 1'b0;
        seg_idx = 3'h0;
        seg_bit = 3'h0;

        // Select crosses by two flip-flops; the word itself is stable while
        // select stays high, so it is sampled once the synchronised edge shows.
        // The master must hold select high for the gap time or the next frame
        // may corrupt the sampled word.
        d.cs_sync = {q.cs_sync[1:0], link.cs_n};
        cs_rise = q.cs_sync[1] && !q.cs_sync[2];
        d.valid = 1'b0;
        if (cs_rise) begin
            d.latch = shift_q;
            d.valid = 1'b1;
        end

        // Commands act one cycle after the strobe. No path returns data.
        if (q.valid) begin
            if (q.latch[15:8] == `LDW_ADDR_SCAN_LIMIT) begin
                d.scan_limit = q.latch[2:0];
            end else if (q.latch[15:8] == `LDW_ADDR_CONFIG) begin
                d.run = q.latch[`LDW_CFG_RUN_BIT];
                if (q.latch[`LDW_CFG_CLEAR_BIT]) begin
                    d.digit = '0;
                end
            end else if (q.latch[12:11] == 2'h0 &&
                         (q.latch[15:13] == `LDW_DIGIT_P0 ||
                          q.latch[15:13] == `LDW_DIGIT_BOTH)) begin
                // Only the first plane drives the pins; the second serves blink,
                // which is not part of this block.
                d.digit[q.latch[10:8]] = q.latch[7:0];
            end
        end

        // Scan runs on the multiplex clock, whose rate is set by the system.
        if (q.run) begin
            if (q.dwell == 10'h0) begin
                d.dwell = 10'(`LDW_DWELL_CYC - 1);
                d.cur = (q.cur >= q.scan_limit) ? 3'h0 : q.cur + 3'h1;
            end else begin
                d.dwell = q.dwell - 10'h1;
            end
        end else begin
            d.cur = 3'h0;
            d.dwell = 10'(`LDW_DWELL_CYC - 1);
        end

        lit_ok = q.run && (FULL_SIZE || q.cur < 3'(`LDW_REDUCED_DIGITS));
        for (int j = 0; j < `LDW_PINS; j++) begin
            d.pin_out[j] = 1'b0;
            d.pin_oe[j] = 1'b0;
            if (lit_ok) begin
                if (j == 8) begin
                    seg_bit = 3'(`LDW_SEG_A_BIT);
                end else begin
                    seg_idx = (3'(j) < q.cur) ? 3'(j) : 3'(j - 1);
                    seg_bit = (seg_idx == 3'h0) ? 3'(`LDW_SEG_DP_BIT) : seg_idx - 3'h1;
                end
                if (j < 8 && 3'(j) == q.cur) begin
                    d.pin_oe[j] = 1'b1;
                end else if (q.digit[q.cur][seg_bit]) begin
                    d.pin_out[j] = 1'b1;
                    d.pin_oe[j] = 1'b1;
                end
            end
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_reset_n) begin
            q <= '0;
            q.cs_sync <= 3'h7;
            q.scan_limit <= `LDW_SCAN_LIMIT_RST;
            q.run <= `LDW_RUN_RST;
        end else begin
            q <= d;
        end
    end

    assign o_cmd_valid = q.valid;
    assign o_cmd_addr = q.latch[15:8];
    assign o_cmd_data = q.latch[7:0];
    assign o_pin_out = q.pin_out;
    assign o_pin_oe = q.pin_oe;
    assign o_running = q.run;

endmodule

`default_nettype wire

// >>> sim/ldw_link_props.sv
`timescale 1ns/1ps
`default_nettype none
module ldw_link_props (
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_reset_n,
    // Link and device outputs
    input wire logic sclk,
    input wire logic cs_n,
    input wire logic mosi,
    input wire logic o_cmd_valid,
    input wire logic [8:0] o_pin_out,
    input wire logic [8:0] o_pin_oe,
    input wire logic o_running
);
    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (!i_reset_n);
    // ==========
    // Properties
    sel_setup_a: assert property ($fell(cs_n) |-> ##4 $rose(sclk))
        else $error("first sclk rise off");
    data_hold_a: assert property (!cs_n && $rose(sclk) |-> $stable(mosi) ##1 $stable(mosi))
        else $error("mosi moved at sclk rise");
    high_half_a: assert property (!cs_n && $rose(sclk) |=> sclk)
        else $error("sclk high too short");
    sel_rest_a: assert property ($rose(cs_n) |-> cs_n [*6])
        else $error("select gap too short");
    latch_delay_a: assert property ($rose(cs_n) |-> ##[3:5] o_cmd_valid)
        else $error("no strobe after select rise");
    strobe_width_a: assert property (o_cmd_valid |=> !o_cmd_valid)
        else $error("strobe wider than one cycle");
    one_cathode_a: assert property ($onehot0(o_pin_oe & ~o_pin_out))
        else $error("two cathodes sink");
    dark_idle_a: assert property (!o_running [*3] |-> o_pin_oe == 9'h000)
        else $error("pins driven while stopped");
endmodule
`default_nettype wire

// >>> sim/led_driver_serial_write_port_test.sv
`timescale 1ns/1ps
`default_nettype none
module led_driver_serial_write_port_test;
    logic i_clk, i_reset_n, i_start, i_idle_high, o_ready, o_cmd_valid, o_running, sclk_q;
    logic [31:0] i_word, lfsr, mon_w;
    logic [5:0] i_nbits;
    logic [15:0] hist;
    logic [7:0] o_cmd_addr, o_cmd_data, seen;
    logic [8:0] o_pin_out, o_pin_oe, small_oe, small_out;
    logic [7:0] digits [8];
    int mismatches, comparisons, cycles, valids, mon_n;
    ldw_if link ();
    ldw_master ldw_master_inst (.i_clk(i_clk), .i_reset_n(i_reset_n), .link(link),
        .i_start(i_start), .i_word(i_word), .i_nbits(i_nbits), .i_idle_high(i_idle_high),
        .o_ready(o_ready));
    ldw_device ldw_device_inst (.i_clk(i_clk), .i_reset_n(i_reset_n), .link(link),
        .o_cmd_valid(o_cmd_valid), .o_cmd_addr(o_cmd_addr), .o_cmd_data(o_cmd_data),
        .o_pin_out(o_pin_out), .o_pin_oe(o_pin_oe), .o_running(o_running));
    // The reduced variant listens to the same link.
    ldw_device #(.FULL_SIZE(1'b0)) ldw_device_small_inst (.i_clk(i_clk),
        .i_reset_n(i_reset_n), .link(link), .o_cmd_valid(), .o_cmd_addr(), .o_cmd_data(),
        .o_pin_out(small_out), .o_pin_oe(small_oe), .o_running());
    ldw_link_props ldw_link_props_inst (.i_clk(i_clk), .i_reset_n(i_reset_n),
        .sclk(link.sclk), .cs_n(link.cs_n), .mosi(link.mosi), .o_cmd_valid(o_cmd_valid),
        .o_pin_out(o_pin_out), .o_pin_oe(o_pin_oe), .o_running(o_running));
    // ==========
    // Helpers
    function automatic logic [31:0] next_rand(input logic [31:0] v);
        return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
    endfunction
    function automatic logic [8:0] lit_pins(input int k, input logic [7:0] d);
        logic [8:0] e;
        int s;
        e = {d[6], 8'h00};
        for (int j = 0; j < 8; j++) begin
            s = (j < k) ? j : j - 1;
            if (j != k) e[j] = d[(s == 0) ? 7 : s - 1];
        end
        return e;
    endfunction
    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        comparisons++;
        if (got !== exp) begin
            mismatches++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic give_verdict();
        $display("Counts: %0d comparisons, %0d mismatches", comparisons, mismatches);
        if (mismatches == 0 && comparisons > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    task automatic send(input logic [31:0] w, input int n, input logic idle);
        int t;
        int v0;
        @(posedge i_clk) #1;
        i_word = w;
        i_nbits = 6'(n);
        i_idle_high = idle;
        i_start = 1'b1;
        mon_n = 0;
        v0 = valids;
        @(posedge i_clk) #1;
        i_start = 1'b0;
        t = 0;
        while (o_ready !== 1'b1 && t < 400) begin
            @(posedge i_clk) #1;
            t++;
        end
        for (int b = n - 1; b >= 0; b--) hist = {hist[14:0], w[b]};
        check("bit count", n, mon_n);
        check("wire bits", w << (32 - n), mon_w << (32 - n));
        check("idle level", 32'(idle), 32'(link.sclk));
        check("strobes", 1, valids - v0);
        check("latched word", 32'(hist), 32'({o_cmd_addr, o_cmd_data}));
    endtask
    task automatic scan_check(input int len, input logic [7:0] want);
        logic [8:0] cath;
        int k;
        seen = 8'h00;
        repeat (len) begin
            @(posedge i_clk) #1;
            cath = o_pin_oe & ~o_pin_out;
            check("small cathode", 32'h0, 32'(small_oe & ~small_out & 9'h0e0));
            if (cath[7:0] != 8'h00) begin
                k = $clog2(cath[7:0]);
                seen[k] = 1'b1;
                check("pin enables", 32'(lit_pins(k, digits[k]) | cath), 32'(o_pin_oe));
                check("pin levels", 32'(lit_pins(k, digits[k])), 32'(o_pin_out & o_pin_oe));
            end
        end
        check("digits scanned", 32'(want), 32'(seen));
    endtask
    // ==========
    // Clock, monitor and timeout
    // The multiplex clock is the bench clock; the system chooses its rate.
    initial begin
        i_clk = 1'b0;
        forever #5 i_clk = ~i_clk;
    end
    always @(posedge i_clk) begin
        cycles <= cycles + 1;
        sclk_q <= link.sclk;
        if (link.cs_n === 1'b0 && link.sclk === 1'b1 && sclk_q === 1'b0) begin
            mon_w <= {mon_w[30:0], link.mosi};
            mon_n <= mon_n + 1;
        end
        if (o_cmd_valid === 1'b1) valids <= valids + 1;
        if (cycles == 20000) begin
            mismatches++;
            give_verdict();
        end
    end
    // ==========
    // Sequence
    initial begin
        i_reset_n = 1'b0;
        i_start = 1'b0;
        i_word = 32'h0;
        i_nbits = 6'h10;
        i_idle_high = 1'b0;
        mismatches = 0;
        comparisons = 0;
        cycles = 0;
        valids = 0;
        mon_n = 0;
        mon_w = 32'h0;
        sclk_q = 1'b0;
        hist = 16'h0;
        lfsr = 32'h00010b07;
        repeat (4) @(posedge i_clk);
        #1;
        i_reset_n = 1'b1;
        check("reset pins", 32'h0, 32'({o_running, o_pin_oe}));
        send(32'h0000a5c3, 16, 1'b0);
        send(32'h12345678, 32, 1'b1);
        send(32'h00000005, 3, 1'b0);
        send(32'h00000001, 1, 1'b1);
        repeat (40) begin
            lfsr = next_rand(lfsr);
            send(lfsr, int'(lfsr[4:0]) + 1, lfsr[5]);
        end
        $display("Test framing done");
        send(32'h00000307, 16, 1'b0);
        for (int k = 0; k < 8; k++) begin
            lfsr = next_rand(lfsr);
            digits[k] = lfsr[7:0];
            send({16'h0, (k[0] ? 8'h60 : 8'h20) + 8'(k), lfsr[7:0]}, 16, k[0]);
        end
        send(32'h00000401, 16, 1'b0);
        scan_check(900, 8'hff);
        for (int k = 0; k < 8; k++) digits[k] = 8'h00;
        send(32'h00000421, 16, 1'b1);
        send(32'h00000302, 16, 1'b0);
        repeat (110) @(posedge i_clk);
        scan_check(400, 8'h07);
        send(32'h00000400, 16, 1'b0);
        repeat (4) @(posedge i_clk);
        check("stopped pins", 32'h0, 32'(o_pin_oe));
        $display("Test display done");
        give_verdict();
    end
endmodule
`default_nettype wire
